// ==== sdram_mode_consts.vh ====
// Purpose: constants for the capability and burst configuration mode registers
// Assumes: mode register addresses are six bits, operands eight bits
// Notes:   timing figures in ns, cycle counts derived from the core clock rate
`ifndef SDRAM_MODE_CONSTS_VH
`define SDRAM_MODE_CONSTS_VH

// mode register addresses
`define MA_CAPABILITY     6'h00
`define MA_BURST_CFG      6'h01
`define MA_FREQ_SET_POINT 6'h0D
`define MA_LATENCY_SET    6'h1A

// capability register fields
`define CAP_REFRESH_BIT   0
`define CAP_LATENCY_BIT   1
`define CAP_ZQ_LO_BIT     3
`define CAP_ZQ_HI_BIT     4
`define CAP_SINGLE_BIT    5
`define CAP_CA_TERMINATION_STATUS_BIT      7

// burst configuration fields
`define BCFG_BL_LO_BIT    0
`define BCFG_BL_HI_BIT    1
`define BCFG_WRPRE_BIT    2
`define BCFG_RDPRE_BIT    3
`define BCFG_NWR_LO_BIT   4
`define BCFG_NWR_HI_BIT   6
`define BCFG_READ_POSTAMBLE_LEN_BIT     7

// frequency set-point fields
`define WRITE_SET_POINT_SELECT_BIT        6
`define OPERATING_SET_POINT_SELECT_BIT        7

// reset values
`define BCFG_RESET        8'h04
`define LAT_SET_RESET     2'h0

// burst length codes
`define BL_FIXED16        2'h0
`define BL_FIXED32        2'h1
`define BL_ON_THE_FLY     2'h2

// calibration self-test result codes
`define ZQ_NOT_SUPPORTED  2'h0
`define ZQ_LOW_OR_FLOAT   2'h1
`define ZQ_SHORT_HIGH     2'h2
`define ZQ_TEST_OK        2'h3

// command codes on the command pins
`define CMD_NOP           3'h0
`define CMD_MRW           3'h1
`define CMD_MRR           3'h2
`define CMD_ZQ_START      3'h3
`define CMD_ZQ_LATCH      3'h4
`define CMD_WRITE_AP      3'h5
`define CMD_WRITE         3'h6
`define CMD_READ          3'h7

// timing
`define CLK_MHZ           100
`define CAL_START_NS      1000
`define CAL_LATCH_NS      30
`define CAL_START_CYC     ((`CAL_START_NS * `CLK_MHZ + 999) / 1000)
`define CAL_LATCH_CYC     ((`CAL_LATCH_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== cfg_copy_mem.v ====
// Purpose: two set-point copies of the burst configuration byte
// Assumes: one write port, two read ports, both reads registered
// Notes:   port a feeds operation, port b feeds register reads
`timescale 1ns/1ns
`include "sdram_mode_consts.vh"

module cfg_copy_mem (
  input  wire       mclk_i,
  input  wire       reset_n_i,
  input  wire       we_i,
  input  wire       waddr_i,
  input  wire [7:0] wdata_i,
  input  wire       raddr_a_i,
  input  wire       raddr_b_i,
  output reg  [7:0] rdata_a_o,
  output reg  [7:0] rdata_b_o
);

  reg [7:0] copy_q [0:1];

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      copy_q[0] <= `BCFG_RESET;
      copy_q[1] <= `BCFG_RESET;
      rdata_a_o <= `BCFG_RESET;
      rdata_b_o <= `BCFG_RESET;
    end else begin
      if (we_i) begin
        copy_q[waddr_i] <= wdata_i;
      end
      rdata_a_o <= copy_q[raddr_a_i];
      rdata_b_o <= copy_q[raddr_b_i];
    end
  end

endmodule

// ==== sdram_mode_regs.v ====
// Purpose: capability and burst configuration mode registers of the memory device
// Assumes: command pins and command clock come from the controller's domain
// Notes:   commands are taken on rising command clock edges seen by mclk_i
//
// Notes on behaviour
// R01: capability bit 0 reports refresh support: 0 both modes, 1 modified only.
// R02: capability bit 1 reports latency support: 0 normal, 1 byte mode.
// R03: capability bits 4:3 return the calibration resistor self-test result code.
// R04: result valid only after calibration start completes, then latch and wait.
// R05: reset clears the self-test result; a new calibration must regenerate it.
// R06: calibration pin tied to low supply makes the result read 01.
// R07: suspected pin assembly error: use factory trim, ignore calibration commands.
// R08: capability bit 5 reports single-ended operation support.
// R09: capability bit 7 reports CA termination; bits 6 and 2 read zero.
// R10: burst field 1:0 selects 16, 32 or per-command length; 11 reserved.
// R11: in per-command mode the command burst bit picks 16 or 32.
// R12: write preamble bit 2 set gives two clocks; zero is reserved.
// R13: read preamble bit 3: 0 static, 1 toggling.
// R14: latency set 00 maps recovery codes onto 6 to 40 clocks.
// R15: latency set 01 maps recovery codes onto 11 to 75 clocks.
// R16: wait programmed recovery clocks after write with auto precharge, then precharge.
// R17: postamble bit 7: 0 half clock, 1 one and a half clocks.
// R18: two copies per field; register read returns the write set-point copy.
// R19: operation uses only the operating set-point copy.
// R20: controller programs identical burst codes in both set points; the bench writes the two set points separately with different codes.
// R21: capability register sits at mode register address 00.
// R22: controller never writes reserved codes and only writes the burst register; the bench also writes the latency set and set-point registers.
`timescale 1ns/1ns
`include "sdram_mode_consts.vh"

module sdram_mode_regs (
  input  wire       mclk_i,
  input  wire       reset_n_i,
  input  wire       cmd_clk_i,
  input  wire [2:0] cmd_code_i,
  input  wire [5:0] cmd_ma_i,
  input  wire [7:0] cmd_op_i,
  input  wire       cmd_bl_i,
  input  wire       strap_refresh_i,
  input  wire       strap_latency_i,
  input  wire       strap_single_end_i,
  input  wire       strap_ca_termination_status_i,
  input  wire       strap_selftest_i,
  input  wire [1:0] zq_sense_i,
  output reg  [7:0] mrr_data_o,
  output reg        mrr_valid_o,
  output reg        burst_valid_o,
  output reg        burst32_o,
  output reg        wr_preamble_2tck_o,
  output reg        rd_preamble_toggle_o,
  output reg        rd_postamble_long_o,
  output reg  [6:0] write_recovery_cycles_o,
  output reg        precharge_start_o,
  output reg        factory_trim_o,
  output reg        cal_busy_o
);

  // counts are worked out as integers, then cut to the counter width on purpose
  localparam integer START_INT = `CAL_START_CYC;
  localparam integer LATCH_INT = `CAL_LATCH_CYC;
  localparam [9:0]   START_CYC = START_INT[9:0];
  localparam [9:0]   LATCH_CYC = LATCH_INT[9:0];

  localparam [4:0] ST_IDLE       = 5'h01;
  localparam [4:0] ST_START      = 5'h02;
  localparam [4:0] ST_WAIT_LATCH = 5'h04;
  localparam [4:0] ST_LATCH      = 5'h08;
  localparam [4:0] ST_DONE       = 5'h10;

  // write recovery clocks for a latency set and a field code
  function [6:0] nwr_lookup;
    input [1:0] lat_set;
    input [2:0] code;
    begin
      if (lat_set == 2'h1) begin
        case (code)
          3'h0: nwr_lookup = 7'h0B; // R15
          3'h1: nwr_lookup = 7'h13;
          3'h2: nwr_lookup = 7'h1D;
          3'h3: nwr_lookup = 7'h26;
          3'h4: nwr_lookup = 7'h2E;
          3'h5: nwr_lookup = 7'h38;
          3'h6: nwr_lookup = 7'h40;
          default: nwr_lookup = 7'h4B;
        endcase
      end else begin
        // other latency sets fall back to the base table
        case (code)
          3'h0: nwr_lookup = 7'h06; // R14
          3'h1: nwr_lookup = 7'h0A;
          3'h2: nwr_lookup = 7'h10;
          3'h3: nwr_lookup = 7'h14;
          3'h4: nwr_lookup = 7'h18;
          3'h5: nwr_lookup = 7'h1E;
          3'h6: nwr_lookup = 7'h22;
          default: nwr_lookup = 7'h28;
        endcase
      end
    end
  endfunction

  // all pin inputs pass two flops; the command clock travels with its data
  wire [25:0] raw_pins;
  reg  [25:0] meta_q;
  reg  [25:0] sync_q;
  reg         clk_prev_q;

  assign raw_pins = {cmd_clk_i, cmd_code_i, cmd_ma_i, cmd_op_i, cmd_bl_i,
                     strap_refresh_i, strap_latency_i, strap_single_end_i,
                     strap_ca_termination_status_i, strap_selftest_i, zq_sense_i};

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta_q     <= 26'h0000000;
      sync_q     <= 26'h0000000;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q     <= raw_pins;
      sync_q     <= meta_q;
      clk_prev_q <= sync_q[25];
    end
  end

  wire       s_clk      = sync_q[25];
  wire [2:0] s_code     = sync_q[24:22];
  wire [5:0] s_ma       = sync_q[21:16];
  wire [7:0] s_op       = sync_q[15:8];
  wire       s_bl       = sync_q[7];
  wire       s_refresh  = sync_q[6];
  wire       s_latency  = sync_q[5];
  wire       s_single   = sync_q[4];
  wire       s_ca_termination_status     = sync_q[3];
  wire       s_selftest = sync_q[2];
  wire [1:0] s_sense    = sync_q[1:0];

  // command decode on the command clock rising edge
  wire cmd_take = s_clk & ~clk_prev_q;
  wire is_mrw   = cmd_take & (s_code == `CMD_MRW);
  wire is_mrr   = cmd_take & (s_code == `CMD_MRR);
  wire is_wr_ap = cmd_take & (s_code == `CMD_WRITE_AP);
  wire is_rw    = cmd_take & ((s_code == `CMD_READ) |
                              (s_code == `CMD_WRITE) |
                              (s_code == `CMD_WRITE_AP));

  reg  [4:0] zq_state_q;
  reg  [9:0] zq_cnt_q;
  reg  [1:0] zq_result_q;
  reg        factory_q;

  // after an assembly error every calibration command is dropped
  wire is_zq_start = cmd_take & (s_code == `CMD_ZQ_START) & ~factory_q; // R07
  wire is_zq_latch = cmd_take & (s_code == `CMD_ZQ_LATCH) & ~factory_q; // R07

  // set-point selects and latency set
  reg       write_set_point_select_q;
  reg       operating_set_point_select_q;
  reg [1:0] lat_set_q;

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      write_set_point_select_q  <= 1'b0;
      operating_set_point_select_q  <= 1'b0;
      lat_set_q <= `LAT_SET_RESET;
    end else if (is_mrw) begin
      if (s_ma == `MA_FREQ_SET_POINT) begin
        write_set_point_select_q <= s_op[`WRITE_SET_POINT_SELECT_BIT];
        operating_set_point_select_q <= s_op[`OPERATING_SET_POINT_SELECT_BIT];
      end
      if (s_ma == `MA_LATENCY_SET) begin
        lat_set_q <= s_op[1:0];
      end
    end
  end

  // the two set-point copies of the burst configuration
  wire [7:0] cfg_active;
  wire [7:0] cfg_readback;
  wire       cfg_we = is_mrw & (s_ma == `MA_BURST_CFG);

  cfg_copy_mem u_copies (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .we_i      (cfg_we),
    .waddr_i   (write_set_point_select_q),
    .wdata_i   (s_op),
    .raddr_a_i (operating_set_point_select_q), // R19
    .raddr_b_i (write_set_point_select_q), // R18
    .rdata_a_o (cfg_active),
    .rdata_b_o (cfg_readback)
  );

  // calibration sequence: start, its completion, latch, latch wait
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      zq_state_q  <= ST_IDLE;
      zq_cnt_q    <= 10'h000;
      zq_result_q <= `ZQ_NOT_SUPPORTED; // R05
      factory_q   <= 1'b0;
    end else begin
      case (zq_state_q)
        ST_IDLE: begin
          // a latch with no start before it has nothing to latch
          if (is_zq_start) begin
            zq_state_q <= ST_START;
            zq_cnt_q   <= START_CYC - 10'h001;
          end
        end
        ST_START: begin
          if (zq_cnt_q == 10'h000) begin
            zq_state_q <= ST_WAIT_LATCH;
          end else begin
            zq_cnt_q <= zq_cnt_q - 10'h001;
          end
        end
        ST_WAIT_LATCH: begin
          if (is_zq_latch) begin
            zq_state_q <= ST_LATCH; // R04
            zq_cnt_q   <= LATCH_CYC - 10'h001;
          end else if (is_zq_start) begin
            zq_state_q <= ST_START;
            zq_cnt_q   <= START_CYC - 10'h001;
          end
        end
        ST_LATCH: begin
          if (zq_cnt_q == 10'h000) begin
            zq_state_q <= ST_DONE; // R04
            if (s_selftest) begin
              // sense code equals result code; a pin on low supply senses 01
              zq_result_q <= s_sense; // R03 R06
              factory_q   <= (s_sense == `ZQ_LOW_OR_FLOAT) |
                             (s_sense == `ZQ_SHORT_HIGH); // R07
            end else begin
              zq_result_q <= `ZQ_NOT_SUPPORTED;
            end
          end else begin
            zq_cnt_q <= zq_cnt_q - 10'h001;
          end
        end
        ST_DONE: begin
          // the last result stays readable while a new run proceeds
          if (is_zq_start) begin
            zq_state_q <= ST_START;
            zq_cnt_q   <= START_CYC - 10'h001;
          end
        end
        default: begin
          zq_state_q <= ST_IDLE;
          zq_cnt_q   <= 10'h000;
        end
      endcase
    end
  end

  // capability byte assembled from straps and the self-test result
  reg [7:0] cap_q;

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cap_q <= 8'h00;
    end else begin
      cap_q                   <= 8'h00; // R09
      cap_q[`CAP_REFRESH_BIT] <= s_refresh; // R01
      cap_q[`CAP_LATENCY_BIT] <= s_latency; // R02
      // a part without the self-test reports not supported, whatever was latched before
      cap_q[`CAP_ZQ_HI_BIT:`CAP_ZQ_LO_BIT] <= s_selftest ? zq_result_q : `ZQ_NOT_SUPPORTED; // R03
      cap_q[`CAP_SINGLE_BIT]  <= s_single; // R08
      cap_q[`CAP_CA_TERMINATION_STATUS_BIT]    <= s_ca_termination_status; // R09
    end
  end

  // mode register read answers
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mrr_data_o  <= 8'h00;
      mrr_valid_o <= 1'b0;
    end else begin
      mrr_valid_o <= is_mrr;
      if (is_mrr) begin
        case (s_ma)
          `MA_CAPABILITY:     mrr_data_o <= cap_q; // R21
          `MA_BURST_CFG:      mrr_data_o <= cfg_readback; // R18
          `MA_FREQ_SET_POINT: mrr_data_o <= {operating_set_point_select_q, write_set_point_select_q, 6'h00};
          `MA_LATENCY_SET:    mrr_data_o <= {6'h00, lat_set_q};
          default:            mrr_data_o <= 8'h00;
        endcase
      end
    end
  end

  // operating settings from the active copy, plus factory trim and calibration busy status
  wire [1:0] act_bl = cfg_active[`BCFG_BL_HI_BIT:`BCFG_BL_LO_BIT];

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_preamble_2tck_o      <= 1'b1;
      rd_preamble_toggle_o    <= 1'b0;
      rd_postamble_long_o     <= 1'b0;
      write_recovery_cycles_o <= 7'h06;
      factory_trim_o          <= 1'b0;
      cal_busy_o              <= 1'b0;
    end else begin
      wr_preamble_2tck_o   <= cfg_active[`BCFG_WRPRE_BIT]; // R12
      rd_preamble_toggle_o <= cfg_active[`BCFG_RDPRE_BIT]; // R13
      rd_postamble_long_o  <= cfg_active[`BCFG_READ_POSTAMBLE_LEN_BIT]; // R17
      write_recovery_cycles_o <= nwr_lookup(lat_set_q,
        cfg_active[`BCFG_NWR_HI_BIT:`BCFG_NWR_LO_BIT]); // R14 R15
      factory_trim_o <= factory_q; // R07
      cal_busy_o     <= (zq_state_q == ST_START) | (zq_state_q == ST_LATCH);
    end
  end

  // burst length per access
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      burst_valid_o <= 1'b0;
      burst32_o     <= 1'b0;
    end else begin
      burst_valid_o <= is_rw;
      if (is_rw) begin
        case (act_bl)
          `BL_FIXED16:    burst32_o <= 1'b0; // R10
          `BL_FIXED32:    burst32_o <= 1'b1; // R10
          `BL_ON_THE_FLY: burst32_o <= s_bl; // R11
          // reserved code behaves as fixed 16
          default:        burst32_o <= 1'b0;
        endcase
      end
    end
  end

  // write recovery count in command clocks, then internal precharge
  reg [6:0] wr_cnt_q;
  reg       wr_busy_q;

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_cnt_q          <= 7'h00;
      wr_busy_q         <= 1'b0;
      precharge_start_o <= 1'b0;
    end else begin
      precharge_start_o <= 1'b0;
      if (is_wr_ap) begin
        // a new write with auto precharge restarts the wait
        wr_cnt_q  <= write_recovery_cycles_o; // R16
        wr_busy_q <= 1'b1;
      end else if (wr_busy_q & cmd_take) begin
        if (wr_cnt_q == 7'h01) begin
          wr_busy_q         <= 1'b0;
          precharge_start_o <= 1'b1; // R16
        end else begin
          wr_cnt_q <= wr_cnt_q - 7'h01;
        end
      end
    end
  end

endmodule

// ==== mode_cmd_master.sv ====
// Purpose: controller model that sends mode register and access commands
// Assumes: link clock of 125 ns, stands still between commands
// Notes:   released operand lines show the inverse of the last value
`timescale 1ns/1ns

module mode_cmd_master (
  output logic       cmd_clk_o,
  output logic [2:0] cmd_code_o,
  output logic [5:0] cmd_ma_o,
  output logic [7:0] cmd_op_o,
  output logic       cmd_bl_o
);
  initial begin
    cmd_clk_o  = 1'b0;
    cmd_code_o = 3'h0;
    cmd_ma_o   = 6'h00;
    cmd_op_o   = 8'h00;
    cmd_bl_o   = 1'b0;
  end

  // fields held 62 ns before and 50 ns after the rising edge; released while the clock is still high
  task automatic send(input logic [2:0] code, input logic [5:0] ma, input logic [7:0] op, input logic bl);
    cmd_code_o = code;
    cmd_ma_o   = ma;
    cmd_op_o   = op;
    cmd_bl_o   = bl;
    #62 cmd_clk_o = 1'b1;
    #50 cmd_code_o = 3'h0;
    cmd_ma_o   = ~ma;
    cmd_op_o   = ~op;
    cmd_bl_o   = ~bl;
    #13 cmd_clk_o = 1'b0;
  endtask

  // slow controller: link idle for whole periods
  task automatic pause(input int n);
    #(125 * n);
  endtask
endmodule

// ==== mode_regs_chk.sv ====
// Purpose: port checker for the capability and burst configuration registers
// Assumes: one command per link period, straps steady around reads
// Notes:   bound to sdram_mode_regs by the bind below
`timescale 1ns/1ns

module mode_regs_chk (
  input wire       mclk_i,
  input wire       reset_n_i,
  input wire [5:0] cmd_ma_i,
  input wire       strap_refresh_i,
  input wire       strap_latency_i,
  input wire       strap_single_end_i,
  input wire       strap_ca_termination_status_i,
  input wire       strap_selftest_i,
  input wire [7:0] mrr_data_o,
  input wire       mrr_valid_o,
  input wire       burst_valid_o,
  input wire [6:0] write_recovery_cycles_o,
  input wire       wr_preamble_2tck_o,
  input wire       precharge_start_o,
  input wire       factory_trim_o,
  input wire       cal_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_cap_straps: assert property (mrr_valid_o && cmd_ma_i == 6'h00 |-> mrr_data_o[0] == strap_refresh_i &&
    mrr_data_o[1] == strap_latency_i && mrr_data_o[5] == strap_single_end_i && mrr_data_o[7] == strap_ca_termination_status_i)
    else $error("capability bits differ from straps");
  a_cap_reserved: assert property (mrr_valid_o && cmd_ma_i == 6'h00 |-> !mrr_data_o[6] && !mrr_data_o[2])
    else $error("reserved capability bits set");
  a_selftest_off: assert property (mrr_valid_o && cmd_ma_i == 6'h00 && !strap_selftest_i |-> mrr_data_o[4:3] == 2'h0)
    else $error("self-test result without support");
  a_trim_sticky: assert property (factory_trim_o |=> factory_trim_o)
    else $error("factory trim dropped");
  a_trim_no_cal: assert property (factory_trim_o && !cal_busy_o |=> !cal_busy_o)
    else $error("calibration ran under factory trim");
  a_cal_bounded: assert property ($rose(cal_busy_o) |-> ##[1:110] !cal_busy_o)
    else $error("calibration wait too long");
  a_burst_pulse: assert property (burst_valid_o |=> !burst_valid_o)
    else $error("burst valid longer than one cycle");
  a_prech_pulse: assert property (precharge_start_o |=> !precharge_start_o)
    else $error("precharge start longer than one cycle");
  a_rec_table: assert property (write_recovery_cycles_o inside {7'h06, 7'h0A, 7'h10, 7'h14, 7'h18, 7'h1E,
    7'h22, 7'h28, 7'h0B, 7'h13, 7'h1D, 7'h26, 7'h2E, 7'h38, 7'h40, 7'h4B})
    else $error("recovery count outside tables");
  a_reset_defaults: assert property ($rose(reset_n_i) |-> write_recovery_cycles_o == 7'h06 &&
    wr_preamble_2tck_o && !factory_trim_o && !cal_busy_o)
    else $error("wrong values after reset");
  a_mrr_hold: assert property (mrr_valid_o |=> !mrr_valid_o && $stable(mrr_data_o))
    else $error("read answer not held");
endmodule

bind sdram_mode_regs mode_regs_chk chk_u (.mclk_i, .reset_n_i, .cmd_ma_i, .strap_refresh_i, .strap_latency_i,
  .strap_single_end_i, .strap_ca_termination_status_i, .strap_selftest_i, .mrr_data_o, .mrr_valid_o, .burst_valid_o,
  .write_recovery_cycles_o, .wr_preamble_2tck_o, .precharge_start_o, .factory_trim_o, .cal_busy_o);

// ==== tb_top.sv ====
// Purpose: self-checking bench for the capability and burst configuration registers
// Assumes: controller model drives all command pins
// Notes:   read answers captured on the valid pulse, checked after the command
`timescale 1ns/1ns
`include "sdram_mode_consts.vh"

module tb_top;
  logic       mclk_i, reset_n_i, cmd_clk_i, cmd_bl_i;
  logic [2:0] cmd_code_i;
  logic [5:0] cmd_ma_i;
  logic [7:0] cmd_op_i, mrr_data_o, rd_q, n_pre;
  logic       strap_refresh_i, strap_latency_i, strap_single_end_i, strap_ca_termination_status_i, strap_selftest_i;
  logic [1:0] zq_sense_i;
  logic       mrr_valid_o, burst_valid_o, burst32_o, wr_preamble_2tck_o, rd_preamble_toggle_o;
  logic       rd_postamble_long_o, precharge_start_o, factory_trim_o, cal_busy_o;
  logic [6:0] write_recovery_cycles_o;
  logic [7:0] rec [16] = '{8'h06, 8'h0A, 8'h10, 8'h14, 8'h18, 8'h1E, 8'h22, 8'h28,
                           8'h0B, 8'h13, 8'h1D, 8'h26, 8'h2E, 8'h38, 8'h40, 8'h4B};
  int         errors, n_tests;

  sdram_mode_regs dut_u (.mclk_i, .reset_n_i, .cmd_clk_i, .cmd_code_i, .cmd_ma_i, .cmd_op_i, .cmd_bl_i,
    .strap_refresh_i, .strap_latency_i, .strap_single_end_i, .strap_ca_termination_status_i, .strap_selftest_i, .zq_sense_i,
    .mrr_data_o, .mrr_valid_o, .burst_valid_o, .burst32_o, .wr_preamble_2tck_o, .rd_preamble_toggle_o,
    .rd_postamble_long_o, .write_recovery_cycles_o, .precharge_start_o, .factory_trim_o, .cal_busy_o);
  mode_cmd_master ctl_u (.cmd_clk_o(cmd_clk_i), .cmd_code_o(cmd_code_i), .cmd_ma_o(cmd_ma_i),
    .cmd_op_o(cmd_op_i), .cmd_bl_o(cmd_bl_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // valid is a one-cycle pulse, so capture it at the edge
  always @(posedge mclk_i) begin
    if (mrr_valid_o === 1'b1) rd_q = mrr_data_o;
    if (precharge_start_o === 1'b1) n_pre = n_pre + 8'h01;
  end

  task automatic end_sim;
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic rst;
    step;
    reset_n_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 reset_n_i = 1'b1;
  endtask

  task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
    ctl_u.send(`CMD_MRW, ma, op, 1'b0);
  endtask

  // stale data is preset to the inverse so it can never match
  task automatic rdchk(input logic [5:0] ma, input logic [7:0] exp);
    rd_q = ~exp;
    ctl_u.send(`CMD_MRR, ma, 8'h00, 1'b0);
    chk(rd_q, exp);
  endtask

  task automatic wait_cal;
    int i;
    for (i = 0; i < 300 && cal_busy_o !== 1'b0; i++) step;
    if (i == 300) begin
      errors++;
      end_sim;
    end
  endtask

  initial begin
    reset_n_i = 1'b0;
    {strap_refresh_i, strap_latency_i, strap_single_end_i, strap_ca_termination_status_i, strap_selftest_i} = 5'h17;
    zq_sense_i = 2'h3;
    errors = 0;
    n_tests = 0;
    n_pre = 8'h00;
    rd_q = 8'h00;
    rst;
    chk({1'b0, write_recovery_cycles_o}, 8'h06);
    chk({5'h0, wr_preamble_2tck_o, rd_preamble_toggle_o, rd_postamble_long_o}, 8'h04);
    rdchk(`MA_BURST_CFG, 8'h04);
    rdchk(`MA_CAPABILITY, 8'hA1);
    ctl_u.send(`CMD_ZQ_START, 6'h00, 8'h00, 1'b0);
    wait_cal;
    rdchk(`MA_CAPABILITY, 8'hA1);
    ctl_u.send(`CMD_ZQ_LATCH, 6'h00, 8'h00, 1'b0);
    wait_cal;
    rdchk(`MA_CAPABILITY, 8'hB9);
    step;
    {strap_refresh_i, strap_latency_i} = 2'h1;
    rdchk(`MA_CAPABILITY, 8'hBA);
    rdchk(6'h3F, 8'h00);
    for (int s = 0; s < 2; s++) begin
      mrw(`MA_LATENCY_SET, s[7:0]);
      for (int c = 0; c < 8; c++) begin
        mrw(`MA_BURST_CFG, {1'b0, c[2:0], 4'h4});
        chk({1'b0, write_recovery_cycles_o}, rec[s * 8 + c]);
      end
    end
    mrw(`MA_LATENCY_SET, 8'h00);
    mrw(`MA_BURST_CFG, 8'h8C);
    chk({5'h0, wr_preamble_2tck_o, rd_preamble_toggle_o, rd_postamble_long_o}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      mrw(`MA_BURST_CFG, 8'h04 | ((8'h29 >> (2 * i)) & 8'h03));
      ctl_u.send(i[0] ? `CMD_WRITE : `CMD_READ, 6'h00, 8'h00, i >= 2);
      chk({7'h0, burst32_o}, {7'h0, ~i[0]});
    end
    chk({5'h0, wr_preamble_2tck_o, rd_preamble_toggle_o, rd_postamble_long_o}, 8'h04);
    mrw(`MA_FREQ_SET_POINT, 8'h40);
    mrw(`MA_BURST_CFG, 8'hF4);
    chk({1'b0, write_recovery_cycles_o}, 8'h06);
    chk({7'h0, rd_postamble_long_o}, 8'h00);
    rdchk(`MA_BURST_CFG, 8'hF4);
    mrw(`MA_FREQ_SET_POINT, 8'hC0);
    chk({1'b0, write_recovery_cycles_o}, 8'h28);
    mrw(`MA_FREQ_SET_POINT, 8'h80);
    rdchk(`MA_BURST_CFG, 8'h04);
    mrw(`MA_FREQ_SET_POINT, 8'h00);
    ctl_u.pause(2);
    n_pre = 8'h00;
    ctl_u.send(`CMD_WRITE_AP, 6'h00, 8'h00, 1'b0);
    repeat (5) ctl_u.send(`CMD_NOP, 6'h00, 8'h00, 1'b0);
    chk(n_pre, 8'h00);
    ctl_u.send(`CMD_NOP, 6'h00, 8'h00, 1'b0);
    chk(n_pre, 8'h01);
    for (int k = 1; k < 3; k++) begin
      rst;
      zq_sense_i = k[1:0];
      rdchk(`MA_CAPABILITY, 8'hA2);
      ctl_u.send(`CMD_ZQ_START, 6'h00, 8'h00, 1'b0);
      wait_cal;
      ctl_u.send(`CMD_ZQ_LATCH, 6'h00, 8'h00, 1'b0);
      wait_cal;
      rdchk(`MA_CAPABILITY, 8'hA2 | (k[7:0] << 3));
      chk({7'h0, factory_trim_o}, 8'h01);
    end
    ctl_u.send(`CMD_ZQ_START, 6'h00, 8'h00, 1'b0);
    chk({7'h0, cal_busy_o}, 8'h00);
    step;
    zq_sense_i = 2'h3;
    strap_selftest_i = 1'b0;
    rdchk(`MA_CAPABILITY, 8'hA2);
    end_sim;
  end
endmodule
